//--- rtl/twl_pkg.sv
// Constants shared by the transceiver reconfiguration word loader
// Function
// - Select 10 sets divide by four
// - Readback 01 means divide by two
// - Channel select width follows channel count
// - Configuration words are 16 bits, strobed
// - Six-bit index names the needed word
// - Image lengths per configuration as listed
// - Full image restores analog control defaults
// - Reduced entry: 6-bit address, 16 data
// - Reduced mode only for image-based modes
// - Divider supports only one, two, four
// - Transmit divider leaves receive dividers alone
// - Divider access needs no image words
package twl_pkg;
    localparam int WORD_W  = 16;
    localparam int ADDR_W  = 6;
    localparam int ENTRY_W = ADDR_W + WORD_W;
    localparam int MEM_DEPTH = 64;

    // Divider select codes
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;
    localparam logic [1:0] DIV_RST = DIV_BY1;

    // Image lengths, selected by image kind
    localparam logic [2:0] IMG_DUPLEX     = 3'h0;
    localparam logic [2:0] IMG_RX_ONLY    = 3'h1;
    localparam logic [2:0] IMG_TX_ONLY    = 3'h2;
    localparam logic [2:0] IMG_DUPLEX_CCU = 3'h3;
    localparam logic [6:0] LEN_DUPLEX     = 7'd55;
    localparam logic [6:0] LEN_RX_ONLY    = 7'd37;
    localparam logic [6:0] LEN_TX_ONLY    = 7'd19;
    localparam logic [6:0] LEN_DUPLEX_CCU = 7'd60;
    localparam logic [6:0] LEN_PD_DUPLEX     = 7'd27;
    localparam logic [6:0] LEN_PD_RX_ONLY    = 7'd14;
    localparam logic [6:0] LEN_PD_TX_ONLY    = 7'd15;
    localparam logic [6:0] LEN_PD_DUPLEX_CCU = 7'd33;

    localparam logic [ADDR_W-1:0] IDX_ZERO = 6'h00;

    typedef enum logic [2:0] {
        TWL_IDLE = 3'b001,
        TWL_FULL = 3'b010,
        TWL_RED  = 3'b100
    } twl_state_t;
endpackage : twl_pkg

//--- rtl/twl_div_bank.sv
// Per-channel transmit local divider settings
`timescale 1ns/1ps
module twl_div_bank #(
    parameter int NUM_CH = 4,
    parameter int CH_W   = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            arst_n,
    input  wire logic            clk_en,
    // Access
    input  wire logic [CH_W-1:0] ch_sel,
    input  wire logic            wr_en,
    input  wire logic [1:0]      wr_code,
    input  wire logic            rd_en,
    output logic      [1:0]      rd_code_ff,
    output logic      [2*NUM_CH-1:0] div_flat
);
    import twl_pkg::*;

    logic       code_ok;
    logic [1:0] legal_code;
    logic [1:0] cur_code;
    logic [1:0] div_ff [NUM_CH];

    // Reserved code 11 is ignored rather than stored
    assign code_ok    = (wr_code == DIV_BY1) || (wr_code == DIV_BY2) || (wr_code == DIV_BY4);
    assign legal_code = (wr_code == DIV_BY4) ? DIV_BY4 :
                        (wr_code == DIV_BY2) ? DIV_BY2 : DIV_BY1;
    assign cur_code   = div_ff[ch_sel];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign div_flat[2*g +: 2] = div_ff[g];
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    div_ff[g] <= DIV_RST;
                end else if (clk_en && wr_en && ch_sel == CH_W'(g) && code_ok) begin
                    div_ff[g] <= legal_code;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_code_ff <= DIV_RST;
        end else if (clk_en && rd_en) begin
            rd_code_ff <= cur_code;
        end
    end
endmodule : twl_div_bank

//--- rtl/twl_loader.sv
// Transceiver reconfiguration word loader top level
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module twl_loader #(
    parameter int  NUM_CH      = 4,
    parameter int  CH_W        = (NUM_CH > 1) ? $clog2(NUM_CH) : 1,
    parameter bit  HAS_RD_PORT = 1'b1,
    parameter bit  HAS_REDUCED = 1'b1
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       arst_n,
    input  wire logic                       clk_en,
    // Image load control
    input  wire logic                       full_start,
    input  wire logic                       reduced_mode,
    input  wire logic                       pma_direct,
    input  wire logic [2:0]                 img_kind,
    input  wire logic [CH_W-1:0]            ch_sel,
    // Image words
    input  wire logic [twl_pkg::WORD_W-1:0] word_data,
    input  wire logic                       word_wr,
    input  wire logic [twl_pkg::ADDR_W-1:0] word_addr_in,
    output logic      [twl_pkg::ADDR_W-1:0] word_idx_ff,
    output logic                            busy,
    output logic                            load_done_ff,
    // Transmit divider
    input  wire logic [1:0]                 div_sel,
    input  wire logic                       div_wr,
    input  wire logic                       div_rd,
    output logic      [1:0]                 div_rb_ff,
    output logic                            div_rb_valid_ff,
    // Channel target
    output logic                            tgt_wr_ff,
    output logic      [CH_W-1:0]            tgt_ch_ff,
    output logic      [twl_pkg::ADDR_W-1:0] tgt_addr_ff,
    output logic      [twl_pkg::WORD_W-1:0] tgt_data_ff,
    output logic      [2*NUM_CH-1:0]        tx_div_ctrl
);
    import twl_pkg::*;

    // ------------------------------------------------------------
    // Image length decode
    // ------------------------------------------------------------
    logic [6:0] img_len;
    logic [6:0] len_full;
    logic [6:0] len_pd;

    assign len_full = (img_kind == IMG_RX_ONLY)    ? LEN_RX_ONLY :
                      (img_kind == IMG_TX_ONLY)    ? LEN_TX_ONLY :
                      (img_kind == IMG_DUPLEX_CCU) ? LEN_DUPLEX_CCU : LEN_DUPLEX;
    assign len_pd   = (img_kind == IMG_RX_ONLY)    ? LEN_PD_RX_ONLY :
                      (img_kind == IMG_TX_ONLY)    ? LEN_PD_TX_ONLY :
                      (img_kind == IMG_DUPLEX_CCU) ? LEN_PD_DUPLEX_CCU : LEN_PD_DUPLEX;
    assign img_len  = pma_direct ? len_pd : len_full;

    // ------------------------------------------------------------
    // Load sequencer
    // ------------------------------------------------------------
    twl_state_t        state_ff, nxt_state;
    logic [ADDR_W-1:0] nxt_idx;
    logic [6:0]        len_ff;
    logic              start_ok;
    logic              red_ok;
    logic              word_take;
    logic              last_word;
    logic              nxt_done;

    // Reduced entries only exist for image-based loads
    assign red_ok    = HAS_REDUCED && reduced_mode;
    assign start_ok  = full_start && (state_ff == TWL_IDLE);
    assign word_take = word_wr && (state_ff != TWL_IDLE);
    assign last_word = ({1'b0, word_idx_ff} == len_ff - 7'd1);
    assign busy      = (state_ff != TWL_IDLE);

    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = word_idx_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            TWL_IDLE: begin
                if (start_ok) begin
                    nxt_state = red_ok ? TWL_RED : TWL_FULL;
                    nxt_idx   = IDX_ZERO;
                end
            end
            TWL_FULL: begin
                if (word_take) begin
                    if (last_word) begin
                        nxt_state = TWL_IDLE;
                        nxt_idx   = IDX_ZERO;
                        nxt_done  = 1'b1;
                    end else begin
                        nxt_idx = word_idx_ff + ADDR_W'(1);
                    end
                end
            end
            TWL_RED: begin
                // Reduced load ends when the caller drops the mode
                if (!reduced_mode) begin
                    nxt_state = TWL_IDLE;
                    nxt_done  = 1'b1;
                end
            end
            default: begin
                nxt_state = TWL_IDLE;
                nxt_idx   = IDX_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= TWL_IDLE;
            word_idx_ff  <= IDX_ZERO;
            len_ff       <= LEN_DUPLEX;
            load_done_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff     <= nxt_state;
            word_idx_ff  <= nxt_idx;
            load_done_ff <= nxt_done;
            if (start_ok) begin
                len_ff <= img_len;
            end
        end
    end

    // ------------------------------------------------------------
    // Word forwarding to the channel
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] wr_addr;
    logic [ENTRY_W-1:0] entry;

    // Reduced entry: address above data
    assign entry   = {word_addr_in, word_data};
    assign wr_addr = (state_ff == TWL_RED) ? entry[ENTRY_W-1 -: ADDR_W] : word_idx_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tgt_wr_ff   <= 1'b0;
            tgt_ch_ff   <= '0;
            tgt_addr_ff <= IDX_ZERO;
            tgt_data_ff <= '0;
        end else if (clk_en) begin
            tgt_wr_ff <= word_take;
            if (word_take) begin
                tgt_ch_ff   <= ch_sel;
                tgt_addr_ff <= wr_addr;
                tgt_data_ff <= entry[WORD_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit divider access, no image involved
    // ------------------------------------------------------------
    logic rd_go;
    logic wr_go;

    // Divider access is refused during a load so a word stream is not split
    assign wr_go = div_wr && !busy;
    assign rd_go = div_rd && !busy && HAS_RD_PORT;

    twl_div_bank #(
        .NUM_CH (NUM_CH),
        .CH_W   (CH_W)
    ) u_div (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .clk_en     (clk_en),
        .ch_sel     (ch_sel),
        .wr_en      (wr_go),
        .wr_code    (div_sel),
        .rd_en      (rd_go),
        .rd_code_ff (div_rb_ff),
        .div_flat   (tx_div_ctrl)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_rb_valid_ff <= 1'b0;
        end else if (clk_en) begin
            div_rb_valid_ff <= rd_go;
        end
    end
endmodule : twl_loader

//--- tb/twl_rom_model.sv
// Image ROM and strobe source standing in for the user logic
`timescale 1ns/1ps
module twl_rom_model (
    // Control
    input  wire logic        sys_clk,
    input  wire logic        go,
    input  wire logic        slow,
    input  wire logic        busy,
    input  wire logic        red,
    input  wire logic [5:0]  idx,
    // Toward the loader
    output logic             word_wr,
    output logic [5:0]       addr_out,
    output logic [15:0]      word_data
);
    logic       ph_ff  = 1'b0;
    logic       wr_ff  = 1'b0;
    logic [5:0] cnt_ff = 6'h00;
    wire  [5:0] a;
    assign word_wr   = wr_ff;
    // Sparse entry addresses, so reduced writes never follow the index
    assign addr_out  = 6'h20 + cnt_ff * 6'h07;
    assign a         = red ? addr_out : idx;
    assign word_data = {a, ~a, 4'hC};
    // Slow mode strobes every other cycle
    always @(posedge sys_clk) begin
        ph_ff   <= slow ? ~ph_ff : 1'b1;
        wr_ff   <= go && busy && (!slow || ph_ff);
        if (word_wr)
            cnt_ff <= cnt_ff + 6'h01;
    end
endmodule : twl_rom_model

//--- tb/twl_loader_chk.sv
// Port assertions for the word loader
`timescale 1ns/1ps
module twl_loader_chk #(
    parameter int NUM_CH = 4,
    parameter int CH_W   = 2
) (
    // Watched ports
    input wire logic                       sys_clk,
    input wire logic                       arst_n,
    input wire logic                       clk_en,
    input wire logic                       reduced_mode,
    input wire logic [CH_W-1:0]            ch_sel,
    input wire logic                       word_wr,
    input wire logic [twl_pkg::ADDR_W-1:0] word_addr_in,
    input wire logic [twl_pkg::ADDR_W-1:0] word_idx_ff,
    input wire logic                       busy,
    input wire logic [1:0]                 div_sel,
    input wire logic                       div_wr,
    input wire logic                       div_rd,
    input wire logic [1:0]                 div_rb_ff,
    input wire logic                       div_rb_valid_ff,
    input wire logic                       tgt_wr_ff,
    input wire logic [twl_pkg::ADDR_W-1:0] tgt_addr_ff,
    input wire logic [2*NUM_CH-1:0]        tx_div_ctrl
);
    wire acc = clk_en && word_wr && busy;
    wire dv  = clk_en && !busy;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    div4_a: assert property (
        dv && div_wr && div_sel == 2'h2 |=> tx_div_ctrl[2*$past(ch_sel) +: 2] == 2'h2) else $error("bad div4");
    code3_a: assert property (
        dv && div_wr && div_sel == 2'h3 |=> $stable(tx_div_ctrl)) else $error("code 11 changed divider");
    rb_a: assert property (
        dv && div_rd |=> div_rb_valid_ff && div_rb_ff == $past(tx_div_ctrl[2*ch_sel +: 2])) else $error("bad rb");
    busy_div_a: assert property (
        busy |=> $stable(tx_div_ctrl)) else $error("divider moved during load");
    idx_step_a: assert property (
        acc && !reduced_mode |=> word_idx_ff == $past(word_idx_ff) + 6'h01 || !busy) else $error("bad index");
    full_addr_a: assert property (
        acc && !reduced_mode |=> tgt_wr_ff && tgt_addr_ff == $past(word_idx_ff)) else $error("bad full addr");
    red_addr_a: assert property (
        acc && reduced_mode |=> tgt_wr_ff && tgt_addr_ff == $past(word_addr_in)) else $error("bad entry addr");
    idle_wr_a: assert property (
        !busy && word_wr |=> !tgt_wr_ff) else $error("idle word taken");
endmodule : twl_loader_chk
bind twl_loader twl_loader_chk #(.NUM_CH(NUM_CH), .CH_W(CH_W)) i_twl_loader_chk (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .reduced_mode(reduced_mode), .ch_sel(ch_sel),
    .word_wr(word_wr), .word_addr_in(word_addr_in), .word_idx_ff(word_idx_ff), .busy(busy),
    .div_sel(div_sel), .div_wr(div_wr), .div_rd(div_rd), .div_rb_ff(div_rb_ff),
    .div_rb_valid_ff(div_rb_valid_ff), .tgt_wr_ff(tgt_wr_ff), .tgt_addr_ff(tgt_addr_ff), .tx_div_ctrl(tx_div_ctrl));

//--- tb/tb.sv
// Self-checking bench for the word loader
`timescale 1ns/1ps
module tb;
    import twl_pkg::*;
    logic       sys_clk = 0, arst_n = 0, full_start = 0, reduced_mode = 0, pma_direct = 0;
    logic       div_wr = 0, div_rd = 0, go = 0, slow = 0, clk_en = 1;
    logic [2:0] img_kind = 0;
    logic [1:0] ch_sel = 0, div_sel = 0;
    logic [7:0] exp_div = 0;
    wire        word_wr, busy, load_done_ff, div_rb_valid_ff, tgt_wr_ff;
    wire [15:0] word_data, tgt_data_ff;
    wire [5:0]  word_addr_in, word_idx_ff, tgt_addr_ff;
    wire [1:0]  div_rb_ff, tgt_ch_ff;
    wire [7:0]  tx_div_ctrl;
    int         err_total = 0, cmp_count = 0, n_wr = 0;
    int         lens[8] = '{55, 37, 19, 60, 27, 14, 15, 33};
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (tgt_wr_ff === 1'b1) n_wr <= n_wr + 1;
    twl_rom_model i_twl_rom_model (.sys_clk(sys_clk), .go(go), .slow(slow), .busy(busy), .red(reduced_mode),
        .idx(word_idx_ff), .word_wr(word_wr), .addr_out(word_addr_in), .word_data(word_data));
    twl_loader i_twl_loader (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .full_start(full_start), .reduced_mode(reduced_mode), .pma_direct(pma_direct), .img_kind(img_kind),
        .ch_sel(ch_sel), .word_data(word_data), .word_wr(word_wr), .word_addr_in(word_addr_in),
        .word_idx_ff(word_idx_ff), .busy(busy), .load_done_ff(load_done_ff), .div_sel(div_sel), .div_wr(div_wr),
        .div_rd(div_rd), .div_rb_ff(div_rb_ff), .div_rb_valid_ff(div_rb_valid_ff), .tgt_wr_ff(tgt_wr_ff),
        .tgt_ch_ff(tgt_ch_ff), .tgt_addr_ff(tgt_addr_ff), .tgt_data_ff(tgt_data_ff), .tx_div_ctrl(tx_div_ctrl));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    // Write then read straight after, as one pair
    task automatic div_op(input int ch, input logic [1:0] code);
        @(posedge sys_clk);
        ch_sel  <= 2'(ch);
        div_sel <= code;
        div_wr  <= 1'b1;
        @(posedge sys_clk);
        div_wr <= 1'b0;
        div_rd <= 1'b1;
        @(posedge sys_clk);
        div_rd <= 1'b0;
        #1;
        if (code != 2'h3) exp_div[2*ch +: 2] = code;
        chk(tx_div_ctrl, exp_div);
        chk({div_rb_valid_ff, div_rb_ff}, {1'b1, exp_div[2*ch +: 2]});
    endtask : div_op
    task automatic load(input int k, input logic red);
        int i;
        i    = 0;
        n_wr = 0;
        @(posedge sys_clk);
        img_kind     <= 3'(k % 4);
        ch_sel       <= 2'(k);
        pma_direct   <= k[2];
        slow         <= k[0];
        reduced_mode <= red;
        full_start   <= 1'b1;
        go           <= 1'b1;
        @(posedge sys_clk);
        full_start <= 1'b0;
        if (red) begin
            div_sel <= 2'h2;
            div_wr  <= 1'b1;
            @(posedge sys_clk);
            div_wr <= 1'b0;
            repeat (5) @(posedge sys_clk);
            go <= 1'b0;
            @(posedge sys_clk);
            reduced_mode <= 1'b0;
        end
        do begin
            @(posedge sys_clk);
            #1;
            i++;
        end while (busy !== 1'b0 && i < 300);
        if (i >= 300) begin
            err_total++;
            tally_and_finish();
        end
        chk(load_done_ff, 1'b1);
        @(posedge sys_clk);
        go <= 1'b0;
        #1;
        if (red) begin
            chk(n_wr, 6);
            chk(tgt_data_ff, {tgt_addr_ff, ~tgt_addr_ff, 4'hC});
            chk(tx_div_ctrl, exp_div);
        end else begin
            chk(n_wr, lens[k]);
            chk(tgt_addr_ff, lens[k] - 1);
            chk(tgt_data_ff, {6'(lens[k] - 1), ~6'(lens[k] - 1), 4'hC});
            chk({tgt_ch_ff, word_idx_ff}, {2'(k), 6'h00});
        end
    endtask : load
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1;
        chk({busy, word_idx_ff, tx_div_ctrl}, 0);
        for (int c = 0; c < 9; c++) div_op(c % 4, (c == 8) ? 2'h3 : 2'(c % 3));
        $display("Divider test done");
        // Clock enable low must swallow a divider write
        @(posedge sys_clk);
        clk_en  <= 1'b0;
        ch_sel  <= 2'h1;
        div_sel <= DIV_BY2;
        div_wr  <= 1'b1;
        @(posedge sys_clk);
        div_wr <= 1'b0;
        @(posedge sys_clk);
        clk_en <= 1'b1;
        #1;
        chk(tx_div_ctrl, exp_div);
        $display("Clock enable test done");
        for (int k = 0; k < 8; k++) load(k, 1'b0);
        $display("Full image test done");
        load(0, 1'b1);
        $display("Reduced image test done");
        tally_and_finish();
    end
    initial begin
        #4000000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb
